// File: region_decode_pkg.sv
// Package: address map constants, attribute encodings and request/result carriers
package region_decode_pkg;

    localparam int ADDR_W = 36;

    // Fixed region bounds
    localparam logic [35:0] SHADOW_BASE    = 36'h0_000C_0000;
    localparam logic [35:0] SHADOW_LIMIT   = 36'h0_000F_FFFF;
    localparam logic [35:0] EXPN_BASE      = 36'h0_000C_0000;
    localparam logic [35:0] EXTFW_BASE     = 36'h0_000E_0000;
    localparam logic [35:0] SYSFW_BASE     = 36'h0_000F_0000;
    localparam logic [35:0] HOLE_BASE      = 36'h0_00F0_0000;
    localparam logic [35:0] HOLE_LIMIT     = 36'h0_00FF_FFFF;
    localparam logic [35:0] ECFG_BASE_DEF  = 36'h0_E000_0000;
    localparam logic [35:0] ECFG_SIZE      = 36'h0_1000_0000;
    localparam logic [35:0] HUBINTC_BASE   = 36'h0_FEC0_0000;
    localparam logic [35:0] HUBINTC_LIMIT  = 36'h0_FEC7_FFFF;
    localparam logic [35:0] PEINTC_BASE    = 36'h0_FEC8_0000;
    localparam logic [35:0] PEINTC_LIMIT   = 36'h0_FEC8_5FFF;
    localparam logic [35:0] MSI_BASE       = 36'h0_FEE0_0000;
    localparam logic [35:0] MSI_LIMIT      = 36'h0_FEEF_FFFF;
    localparam logic [35:0] HIGHMGMT_BASE  = 36'h0_FEDA_0000;
    localparam logic [35:0] HIGHMGMT_LIMIT = 36'h0_FEDB_FFFF;
    localparam logic [35:0] LOWMGMT_BASE   = 36'h0_000A_0000;
    localparam logic [35:0] ZERO_ADDR      = 36'h0_0000_0000;

    // Segment index fields
    localparam int SEG16_LSB   = 14;
    localparam int PEWIN_LSB   = 12;
    localparam int NUM_EXPN    = 8;
    localparam int NUM_EXTFW   = 4;
    localparam int NUM_PE      = 6;

    // Top management segment sizes
    localparam logic [35:0] TOP_MGMT_SEGMENT_128K = 36'h0_0002_0000;
    localparam logic [35:0] TOP_MGMT_SEGMENT_256K = 36'h0_0004_0000;
    localparam logic [35:0] TOP_MGMT_SEGMENT_512K = 36'h0_0008_0000;
    localparam logic [35:0] TOP_MGMT_SEGMENT_1M   = 36'h0_0010_0000;

    // Attribute: bit0 read enable, bit1 write enable
    typedef enum logic [1:0] {
        ATTR_DISABLED  = 2'h0,
        ATTR_READ_ONLY = 2'h1,
        ATTR_WRITE_ONLY = 2'h2,
        ATTR_READ_WRITE = 2'h3
    } shadow_attr_t;
    localparam int ATTR_RD_BIT = 0;
    localparam int ATTR_WR_BIT = 1;
    localparam logic [1:0] ATTR_RESET = 2'h0;

    typedef enum logic [2:0] {
        TGT_MEMORY  = 3'h0,
        TGT_HUB     = 3'h1,
        TGT_PCIE    = 3'h2,
        TGT_SYSBUS  = 3'h3,
        TGT_SPECIAL = 3'h4,
        TGT_ABORT   = 3'h5,
        TGT_INTERNAL = 3'h6,
        TGT_CFG     = 3'h7
    } target_t;

    typedef enum logic [2:0] {
        SRC_SYSBUS = 3'h0,
        SRC_HUB    = 3'h1,
        SRC_PCIE   = 3'h2
    } source_t;

    typedef struct packed {
        logic [35:0] addr;
        logic        write;
        logic        mgmt;
        logic        code;
        source_t     src;
    } request_t;

    typedef struct packed {
        target_t     target;
        logic [2:0]  port;
        logic [35:0] addr;
        logic        byte_en_kill;
        logic        target_ready_n;
    } route_t;

    typedef struct packed {
        logic        global_mgmt_mem_enable;
        logic        open;
        logic        top_mgmt_segment_enable;
        logic        high_window_enable;
        logic [1:0]  segment_size_sel;
        logic        hole_enable_field;
        logic        intc_window_disable;
        logic [35:0] low_memory_top;
        logic [35:0] ecfg_base;
    } map_cfg_t;

endpackage

// File: shadow_attr_lookup.sv
// Shadow attribute lookup for the 768 KB to 1 MB area
`timescale 1ns/10ps
module shadow_attr_lookup
    import region_decode_pkg::*;
(
    // Attribute state
    input  wire logic [NUM_EXPN*2-1:0]  expn_attr,
    input  wire logic [NUM_EXTFW*2-1:0] extfw_attr,
    input  wire logic [1:0]             sysfw_attr,
    // Lookup
    input  wire logic [35:0]            addr,
    output logic                        hit,
    output logic [1:0]                  attr
);
    logic [2:0] seg;

    always_comb begin
        seg  = addr[SEG16_LSB+2:SEG16_LSB];
        hit  = (addr >= SHADOW_BASE) && (addr <= SHADOW_LIMIT);
        attr = ATTR_RESET;
        if (addr >= SYSFW_BASE) begin
            attr = sysfw_attr;
        end else if (addr >= EXTFW_BASE) begin
            attr = extfw_attr[seg[1:0]*2 +: 2];
        end else if (addr >= EXPN_BASE) begin
            attr = expn_attr[seg*2 +: 2];
        end
    end
endmodule

// File: top_mgmt_segment_window.sv
// Top management segment window from low memory top and size select
`timescale 1ns/10ps
module top_mgmt_segment_window
    import region_decode_pkg::*;
(
    // Configuration
    input  wire logic [35:0] low_memory_top,
    input  wire logic [1:0]  segment_size_sel,
    // Lookup
    input  wire logic [35:0] addr,
    output logic             hit
);
    logic [35:0] size;
    logic [35:0] base;

    always_comb begin
        case (segment_size_sel)
            2'h0:    size = TOP_MGMT_SEGMENT_128K;
            2'h1:    size = TOP_MGMT_SEGMENT_256K;
            2'h2:    size = TOP_MGMT_SEGMENT_512K;
            default: size = TOP_MGMT_SEGMENT_1M;
        endcase
        base = low_memory_top - size;
        hit  = (addr >= base) && (addr < low_memory_top);
    end
endmodule

// File: legacy_region_address_decoder.sv
// Routing decoder for legacy, management and interrupt regions of the system map
`timescale 1ns/10ps
module legacy_region_address_decoder
    import region_decode_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    // Attribute writes from configuration logic
    input  wire logic                   attr_wr,
    input  wire logic [3:0]             attr_idx,
    input  wire logic [1:0]             attr_val,
    // Map configuration
    input  wire map_cfg_t               cfg,
    // Request
    input  wire logic                   req_valid,
    input  wire request_t               req,
    // Routed result
    output logic                        rsp_valid,
    output route_t                      rsp,
    // Attribute state readback
    output logic [NUM_EXPN*2-1:0]       expn_attr_q,
    output logic [NUM_EXTFW*2-1:0]      extfw_attr_q,
    output logic [1:0]                  sysfw_attr_q
);
    localparam logic [3:0] SYSFW_IDX = 4'hC;

    function automatic logic in_range(input logic [35:0] a, input logic [35:0] lo,
                                      input logic [35:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic attr_allows(input logic [1:0] at, input logic wr);
        attr_allows = wr ? at[ATTR_WR_BIT] : at[ATTR_RD_BIT];
    endfunction

    // Attribute storage, each segment its own register slice
    genvar g;
    generate
        for (g = 0; g < NUM_EXPN; g++) begin : g_expn
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    expn_attr_q[g*2 +: 2] <= ATTR_RESET;
                end else if (attr_wr && attr_idx == 4'(g)) begin
                    expn_attr_q[g*2 +: 2] <= attr_val;
                end
            end
        end
        for (g = 0; g < NUM_EXTFW; g++) begin : g_extfw
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    extfw_attr_q[g*2 +: 2] <= ATTR_RESET;
                end else if (attr_wr && attr_idx == 4'(g + NUM_EXPN)) begin
                    extfw_attr_q[g*2 +: 2] <= attr_val;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sysfw_attr_q <= ATTR_RESET;
        end else if (attr_wr && attr_idx == SYSFW_IDX) begin
            sysfw_attr_q <= attr_val;
        end
    end

    // Region lookups
    logic       shadow_hit;
    logic [1:0] shadow_attr;
    logic       top_mgmt_segment_hit;

    shadow_attr_lookup i_shadow_attr_lookup (
        .expn_attr  (expn_attr_q),
        .extfw_attr (extfw_attr_q),
        .sysfw_attr (sysfw_attr_q),
        .addr       (req.addr),
        .hit        (shadow_hit),
        .attr       (shadow_attr)
    );

    top_mgmt_segment_window i_top_mgmt_segment_window (
        .low_memory_top   (cfg.low_memory_top),
        .segment_size_sel (cfg.segment_size_sel),
        .addr             (req.addr),
        .hit              (top_mgmt_segment_hit)
    );

    logic        inbound;
    logic        hole_hit;
    logic        ecfg_hit;
    logic        hubintc_hit;
    logic        peintc_hit;
    logic        msi_hit;
    logic        high_hit;
    logic        mgmt_ok;
    logic [2:0]  pe_port;
    route_t      rsp_d;

    always_comb begin
        inbound     = (req.src != SRC_SYSBUS);
        hole_hit    = in_range(req.addr, HOLE_BASE, HOLE_LIMIT);
        ecfg_hit    = in_range(req.addr, cfg.ecfg_base, cfg.ecfg_base + ECFG_SIZE - 36'h1);
        hubintc_hit = in_range(req.addr, HUBINTC_BASE, HUBINTC_LIMIT);
        peintc_hit  = in_range(req.addr, PEINTC_BASE, PEINTC_LIMIT);
        msi_hit     = in_range(req.addr, MSI_BASE, MSI_LIMIT);
        high_hit    = in_range(req.addr, HIGHMGMT_BASE, HIGHMGMT_LIMIT);
        pe_port     = req.addr[PEWIN_LSB+2:PEWIN_LSB];
        // Open space or a management code fetch may reach management memory
        mgmt_ok     = cfg.global_mgmt_mem_enable && (cfg.open || (req.mgmt && req.code));
    end

    // Decision, ordered so fixed high windows win over subtractive ranges
    always_comb begin
        rsp_d                = '0;
        rsp_d.target         = TGT_MEMORY;
        rsp_d.addr           = req.addr;
        rsp_d.target_ready_n = 1'b1;
        if (msi_hit) begin
            if (!req.write) begin
                rsp_d.target = TGT_ABORT;
            end else begin
                // Forwarded or local, the device closes the bus phase itself
                rsp_d.target         = TGT_SYSBUS;
                rsp_d.target_ready_n = 1'b0;
            end
        end else if (high_hit && cfg.global_mgmt_mem_enable && cfg.high_window_enable) begin
            if (inbound) begin
                rsp_d.target = TGT_SPECIAL;
                rsp_d.addr   = ZERO_ADDR;
                rsp_d.byte_en_kill = req.write;
            end else if (mgmt_ok) begin
                rsp_d.addr = LOWMGMT_BASE + (req.addr - HIGHMGMT_BASE);
            end else begin
                rsp_d.target = TGT_SPECIAL;
            end
        end else if (!inbound && hubintc_hit) begin
            rsp_d.target = TGT_HUB;
        end else if (!inbound && peintc_hit) begin
            if (cfg.intc_window_disable) begin
                rsp_d.target = TGT_HUB;
            end else begin
                rsp_d.target = TGT_PCIE;
                rsp_d.port   = pe_port;
            end
        end else if (ecfg_hit) begin
            rsp_d.target = TGT_CFG;
        end else if (top_mgmt_segment_hit && cfg.global_mgmt_mem_enable && cfg.top_mgmt_segment_enable) begin
            if (inbound) begin
                rsp_d.target       = TGT_SPECIAL;
                rsp_d.addr         = ZERO_ADDR;
                rsp_d.byte_en_kill = req.write;
            end else if (mgmt_ok && (req.mgmt || cfg.open)) begin
                rsp_d.target = TGT_MEMORY;
            end else begin
                rsp_d.target = TGT_SPECIAL;
            end
        end else if (hole_hit && cfg.hole_enable_field) begin
            rsp_d.target = TGT_HUB;
        end else if (shadow_hit) begin
            if (inbound) begin
                // Attributes deliberately ignored for inbound traffic
                rsp_d.target = req.write ? TGT_HUB : TGT_INTERNAL;
            end else if (attr_allows(shadow_attr, req.write)) begin
                rsp_d.target = TGT_MEMORY;
            end else begin
                rsp_d.target = TGT_HUB;
            end
        end
        // Anything left, including disabled management windows, is memory
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= req_valid;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp <= '{target: TGT_MEMORY, port: 3'h0, addr: ZERO_ADDR,
                     byte_en_kill: 1'b0, target_ready_n: 1'b1};
        end else if (req_valid) begin
            rsp <= rsp_d;
        end
    end

    // Checks
    a_msi_read_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_valid && msi_hit && !req.write |=> rsp_valid && rsp.target == TGT_ABORT)
        else $error("interrupt range read not aborted");
    a_msi_inbound_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_valid && msi_hit && req.write && inbound |=> rsp.target == TGT_SYSBUS)
        else $error("inbound interrupt write not sent to system bus");
    a_msi_target_ready_n_end: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_valid && msi_hit && req.write |=> !rsp.target_ready_n)
        else $error("system bus interrupt write not ended");
    a_shadow_in_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_valid && inbound && req.write && shadow_hit && !msi_hit
        |=> rsp.target == TGT_HUB)
        else $error("inbound shadow write not sent to hub");
    a_shadow_in_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_valid && inbound && !req.write && shadow_hit |=> rsp.target == TGT_INTERNAL)
        else $error("inbound shadow read not internal");
    a_hole_routing: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_valid && hole_hit && cfg.hole_enable_field && !top_mgmt_segment_hit
        |=> rsp.target == TGT_HUB)
        else $error("hole access not sent to hub");
    a_sysfw_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> sysfw_attr_q == ATTR_RESET)
        else $error("firmware attributes not disabled after reset");
    a_inbound_mgmt_kill: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_valid && inbound && req.write && top_mgmt_segment_hit && cfg.global_mgmt_mem_enable
        && cfg.top_mgmt_segment_enable && !ecfg_hit && !msi_hit && !high_hit
        |=> rsp.byte_en_kill && rsp.target == TGT_SPECIAL)
        else $error("inbound management write not discarded");
    a_high_remap: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_valid && !inbound && high_hit && mgmt_ok && cfg.high_window_enable
        |=> rsp.addr == LOWMGMT_BASE + ($past(req.addr) - HIGHMGMT_BASE))
        else $error("high window not remapped");
    a_intc_disable: assert property (@(posedge core_clk) disable iff (!rst_n)
        req_valid && !inbound && peintc_hit && cfg.intc_window_disable
        |=> rsp.target == TGT_HUB)
        else $error("disabled interrupt window not sent to hub");

    c_msi_write:  cover property (@(posedge core_clk) req_valid && msi_hit && req.write);
    c_remap:      cover property (@(posedge core_clk) req_valid && high_hit && mgmt_ok);
    c_shadow_mem: cover property (@(posedge core_clk)
        req_valid && shadow_hit && !inbound && attr_allows(shadow_attr, req.write));
    c_top_mgmt_segment_term:  cover property (@(posedge core_clk)
        req_valid && top_mgmt_segment_hit && cfg.top_mgmt_segment_enable && !req.mgmt && !cfg.open);
endmodule

// File: request_source.sv
// Request source model for the system bus and the inbound ports
`timescale 1ns/10ps
module request_source
    import region_decode_pkg::*;
(
    // Clock
    input  wire logic core_clk,
    // Request out
    output request_t  req,
    output logic      req_valid
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    task automatic issue(input request_t r);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= r;
    endtask

    // Released lines flip so a stale request never looks current
    task automatic idle();
        @(posedge core_clk);
        req_valid <= 1'b0;
        req <= ~req;
    endtask
endmodule

// File: legacy_region_address_decoder_tb_top.sv
// Self-checking testbench for the legacy region address decoder
`timescale 1ns/10ps
module legacy_region_address_decoder_tb_top
    import region_decode_pkg::*;
;
    localparam logic [35:0] TOP = 36'h0_8000_0000;
    typedef struct packed {
        logic [3:0] m;
        route_t     r;
    } note_t;

    logic                     core_clk;
    logic                     rst_n;
    logic                     attr_wr;
    logic [3:0]               attr_idx;
    logic [1:0]               attr_val;
    map_cfg_t                 cfg;
    logic                     req_valid;
    request_t                 req;
    logic                     rsp_valid;
    route_t                   rsp;
    logic [NUM_EXPN*2-1:0]    expn_attr_q;
    logic [NUM_EXTFW*2-1:0]   extfw_attr_q;
    logic [1:0]               sysfw_attr_q;
    int                       bad_count;
    int                       num_checks;
    int                       cyc;
    integer                   seed;
    note_t                    q[$];
    note_t                    n;
    route_t                   ex;
    logic [3:0]               em;
    logic                     mg;
    logic                     cd;
    logic [35:0]              b;
    logic [35:0]              off;

    legacy_region_address_decoder i_legacy_region_address_decoder (
        .core_clk(core_clk), .rst_n(rst_n), .attr_wr(attr_wr), .attr_idx(attr_idx),
        .attr_val(attr_val), .cfg(cfg), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp), .expn_attr_q(expn_attr_q),
        .extfw_attr_q(extfw_attr_q), .sysfw_attr_q(sysfw_attr_q));

    request_source i_request_source (.core_clk(core_clk), .req(req), .req_valid(req_valid));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One request; the expected route is noted for the monitor
    task automatic go(input logic [35:0] a, input logic w, input source_t s, input target_t t);
        i_request_source.issue(request_t'{a, w, mg, cd, s});
        ex.target = t;
        q.push_back(note_t'{em, ex});
        em = 4'h0;
    endtask

    task automatic sa(input int i, input int v);
        logic [1:0] rb;
        i_request_source.idle();
        attr_wr <= 1'b1;
        attr_idx <= 4'(i);
        attr_val <= 2'(v);
        @(posedge core_clk);
        attr_wr <= 1'b0;
        #1;
        rb = (i < 8) ? expn_attr_q[2*i+:2] : (i < 12) ? extfw_attr_q[2*(i-8)+:2] : sysfw_attr_q;
        chk("attr", 36'(v), 36'(rb));
    endtask

    // Results arrive one cycle after the request, looked at mid-cycle
    always @(negedge core_clk) begin
        if (rst_n === 1'b1 && rsp_valid === 1'b1) begin
            if (q.size() == 0) begin
                chk("extra rsp", 36'h0, 36'h1);
            end else begin
                n = q.pop_front();
                chk("target", 36'(n.r.target), 36'(rsp.target));
                if (n.m[0]) chk("port", 36'(n.r.port), 36'(rsp.port));
                if (n.m[1]) chk("addr", n.r.addr, rsp.addr);
                if (n.m[2]) chk("kill", 36'(n.r.byte_en_kill), 36'(rsp.byte_en_kill));
                if (n.m[3]) chk("target_ready_n_n", 36'(n.r.target_ready_n), 36'(rsp.target_ready_n));
            end
        end
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        seed = 32'h19c050e9;
        rst_n = 1'b0;
        attr_wr = 1'b0;
        attr_idx = 4'h0;
        attr_val = 2'h0;
        cfg = '0;
        cfg.low_memory_top = TOP;
        cfg.ecfg_base = ECFG_BASE_DEF;
        cfg.intc_window_disable = 1'b1;
        ex = '0;
        em = 4'h0;
        mg = 1'b0;
        cd = 1'b0;
        repeat (10) @(posedge core_clk);
        chk("rsp_valid", 36'h0, 36'(rsp_valid));
        chk("attr rst", 36'h0, {10'h000, expn_attr_q, extfw_attr_q, sysfw_attr_q});
        rst_n <= 1'b1;
        go(SYSFW_BASE, 1'b0, SRC_SYSBUS, TGT_HUB);
        go(SHADOW_LIMIT, 1'b1, SRC_SYSBUS, TGT_HUB);
        for (int i = 0; i < 13; i++) begin
            for (int v = 0; v < 4; v++) begin
                sa(i, v);
                b = SHADOW_BASE + (36'(i) << SEG16_LSB) + (36'($random(seed)) & 36'h0_0000_3FFF);
                go(b, 1'b0, SRC_SYSBUS, v[ATTR_RD_BIT] ? TGT_MEMORY : TGT_HUB);
                go(b, 1'b1, SRC_SYSBUS, v[ATTR_WR_BIT] ? TGT_MEMORY : TGT_HUB);
            end
        end
        // Attributes now all read/write, so inbound must ignore them
        for (int s = 1; s < 3; s++) begin
            for (int k = 0; k < 3; k++) begin
                b = (k == 0) ? SHADOW_BASE : (k == 1) ? EXTFW_BASE + 36'h8000 : SHADOW_LIMIT;
                go(b, 1'b1, source_t'(s), TGT_HUB);
                go(b, 1'b0, source_t'(s), TGT_INTERNAL);
            end
        end
        for (int k = 0; k < 4; k++) begin
            i_request_source.idle();
            cfg.hole_enable_field <= k[0];
            b = HOLE_BASE + (36'($random(seed)) & 36'h0_000F_FFFF);
            go(b, k[1], SRC_SYSBUS, k[0] ? TGT_HUB : TGT_MEMORY);
            go(HOLE_LIMIT, 1'b0, SRC_PCIE, k[0] ? TGT_HUB : TGT_MEMORY);
            go(HOLE_LIMIT + 1, 1'b1, SRC_SYSBUS, TGT_MEMORY);
        end
        i_request_source.idle();
        cfg.global_mgmt_mem_enable <= 1'b1;
        cfg.top_mgmt_segment_enable <= 1'b1;
        for (int z = 0; z < 4; z++) begin
            i_request_source.idle();
            cfg.segment_size_sel <= 2'(z);
            b = TOP - (TOP_MGMT_SEGMENT_128K << z);
            go(b, 1'b0, SRC_SYSBUS, TGT_SPECIAL);
            go(TOP - 1, 1'b1, SRC_SYSBUS, TGT_SPECIAL);
            go(b - 1, 1'b0, SRC_SYSBUS, TGT_MEMORY);
            go(TOP, 1'b0, SRC_SYSBUS, TGT_MEMORY);
            mg = 1'b1;
            cd = 1'b1;
            go(b, 1'b0, SRC_SYSBUS, TGT_MEMORY);
            cd = 1'b0;
            // Management data access is no code fetch: still refused
            go(b, 1'b0, SRC_SYSBUS, TGT_SPECIAL);
            mg = 1'b0;
        end
        i_request_source.idle();
        cfg.open <= 1'b1;
        go(b, 1'b1, SRC_SYSBUS, TGT_MEMORY);
        em = 4'h2;
        ex.addr = ZERO_ADDR;
        go(b, 1'b0, SRC_HUB, TGT_SPECIAL);
        em = 4'h4;
        ex.byte_en_kill = 1'b1;
        go(b + 4, 1'b1, SRC_PCIE, TGT_SPECIAL);
        i_request_source.idle();
        cfg.top_mgmt_segment_enable <= 1'b0;
        go(b, 1'b0, SRC_SYSBUS, TGT_MEMORY);
        go(b, 1'b1, SRC_HUB, TGT_MEMORY);
        go(ECFG_BASE_DEF, 1'b0, SRC_SYSBUS, TGT_CFG);
        go(ECFG_BASE_DEF + ECFG_SIZE - 1, 1'b1, SRC_SYSBUS, TGT_CFG);
        go(HUBINTC_BASE, 1'b0, SRC_SYSBUS, TGT_HUB);
        go(PEINTC_BASE + 36'h123, 1'b1, SRC_SYSBUS, TGT_HUB);
        i_request_source.idle();
        cfg.intc_window_disable <= 1'b0;
        go(HUBINTC_LIMIT, 1'b1, SRC_SYSBUS, TGT_HUB);
        for (int i = 0; i < NUM_PE; i++) begin
            em = 4'h1;
            ex.port = 3'(i);
            off = 36'($random(seed)) & 36'h0_0000_0FFF;
            go(PEINTC_BASE + (36'(i) << PEWIN_LSB) + off, off[0], SRC_SYSBUS, TGT_PCIE);
        end
        for (int s = 0; s < 3; s++) begin
            em = 4'h8;
            ex.target_ready_n = 1'b0;
            off = 36'($random(seed)) & 36'h0_000F_FFFF;
            go(MSI_BASE + off, 1'b1, source_t'(s), TGT_SYSBUS);
            go(MSI_LIMIT - 36'(s), 1'b0, source_t'(s), TGT_ABORT);
        end
        i_request_source.idle();
        cfg.high_window_enable <= 1'b1;
        mg = 1'b1;
        off = 36'($random(seed)) & 36'h0_0001_FFFF;
        em = 4'h2;
        ex.addr = LOWMGMT_BASE + off;
        go(HIGHMGMT_BASE + off, 1'b0, SRC_SYSBUS, TGT_MEMORY);
        em = 4'h2;
        ex.addr = 36'h0_000B_FFFF;
        go(HIGHMGMT_LIMIT, 1'b1, SRC_SYSBUS, TGT_MEMORY);
        mg = 1'b0;
        em = 4'h2;
        ex.addr = ZERO_ADDR;
        go(HIGHMGMT_BASE, 1'b0, SRC_HUB, TGT_SPECIAL);
        i_request_source.idle();
        cfg.high_window_enable <= 1'b0;
        mg = 1'b1;
        em = 4'h2;
        ex.addr = HIGHMGMT_BASE;
        go(HIGHMGMT_BASE, 1'b0, SRC_SYSBUS, TGT_MEMORY);
        i_request_source.idle();
        repeat (3) @(posedge core_clk);
        chk("pending", 36'h0, 36'(q.size()));
        close_out();
    end
endmodule
